// File: hw/sdt_consts.svh
`ifndef SDT_CONSTS_SVH
`define SDT_CONSTS_SVH
// Array organisation: four banks of 4096 rows.
`define SDT_BANK_W 2
`define SDT_NUM_BANKS 4
`define SDT_ROW_W 12
// Default column width is the 16-bit organisation (256 columns).
`define SDT_COL_W 8
`define SDT_DQ_W 16
`define SDT_MASK_W 2
// Burst length is two to this power.
`define SDT_BL_W 2
// Address bit that selects auto precharge or all-bank precharge.
`define SDT_PRE_SEL_BIT 10
// Read latency after reset, and the smallest legal latency.
`define SDT_RL_RST 2'd3
`define SDT_RL_MIN 2'd1
// Auto refreshes needed after power-up before normal operation.
`define SDT_INIT_REFRESHES 2'd2
`endif

// File: hw/sdt_pkg.sv
package sdt_pkg;
   // Decoded command on the pins at one rising edge.
   typedef enum logic [2:0] {
      SDT_NOP, SDT_ACT, SDT_RD, SDT_WR, SDT_BST, SDT_PRE, SDT_REF, SDT_LMR
   } sdt_cmd_t;
   // Kind of burst in progress.
   typedef enum logic [1:0] {
      SDT_IDLE, SDT_READ, SDT_WRITE
   } sdt_burst_t;
endpackage

// File: hw/sdt_sdram_core.sv
// Summary of operation
// - Column commands accepted on every clock.
// - Clock-gate low suspends one clock later.
// - Write mask blocks data on same edge.
// - Read mask floats outputs two clocks later.
// - First write beat captured with write command.
// - Clock-gate high resumes one clock later.
// - Precharge ends read after read latency clocks.
// - All inputs but rst_b sampled on rising clock edge.
// - Four banks, 4096 rows, width-dependent columns.
// - Activate picks bank and row, then column.
// - Column start taken from low address bits.
// - Precharge-select bit requests auto precharge.
`include "sdt_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sdt_sdram_core
   import sdt_pkg::*;
#(
   parameter int DQ_W = `SDT_DQ_W,
   parameter int MASK_W = `SDT_MASK_W,
   parameter int COL_W = `SDT_COL_W,
   parameter int ROW_W = `SDT_ROW_W,
   parameter int ROW_STORE_W = `SDT_ROW_W,
   parameter int BL_W = `SDT_BL_W
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cke,
   input wire logic cs_b,
   input wire logic ras_b,
   input wire logic cas_b,
   input wire logic we_b,
   input wire logic bank_sel_lo,
   input wire logic bank_sel_hi,
   input wire logic [ROW_W-1:0] addr,
   input wire logic [MASK_W-1:0] dqm,
   input wire logic [DQ_W-1:0] dq_in,
   input wire logic [1:0] read_latency,
   output logic [DQ_W-1:0] dq_out,
   output logic [MASK_W-1:0] dq_oe,
   output logic suspended,
   output logic [`SDT_NUM_BANKS-1:0] bank_open,
   output logic init_done,
   output logic cmd_error
);

   // *************************************************************
   // Local sizes and the state record
   // *************************************************************

   localparam int BW = `SDT_BANK_W;
   localparam int NB = `SDT_NUM_BANKS;
   localparam int LANE_W = DQ_W / MASK_W;
   localparam int MEM_AW = BW + ROW_STORE_W + COL_W;
   // Beats that follow the one taken with the column command.
   localparam logic [BL_W:0] BEATS_AFTER =
      (BL_W+1)'((1 << BL_W) - 1);

   // All control state lives in one record so reset is uniform.
   typedef struct packed {
      logic cke_d;                  // Clock gate seen at last edge.
      logic [MASK_W-1:0] dqm_d;     // Mask seen at last edge.
      logic [NB-1:0] open;          // Bank has an active row.
      logic [NB-1:0][ROW_W-1:0] row; // Active row per bank.
      logic [1:0] rl;               // Programmed read latency.
      sdt_burst_t burst;            // Burst in progress.
      logic [BW-1:0] bank;          // Bank of the burst.
      logic [COL_W-1:0] col;        // Column of the next beat.
      logic [BL_W:0] left;          // Beats still to come.
      logic ap;                     // Burst ends in precharge.
      logic p0v;                    // Read pipe stage one.
      logic [DQ_W-1:0] p0d;
      logic p1v;                    // Read pipe stage two.
      logic [DQ_W-1:0] p1d;
      logic [DQ_W-1:0] dout;        // Data driven on the pins.
      logic [MASK_W-1:0] oe;        // Per-lane output enable.
      logic [1:0] refs;             // Refreshes since reset.
      logic ready;                  // Wake-up refreshes seen.
      logic err;                    // Illegal command this edge.
   } sdt_state_t;

   sdt_state_t r;   // Registered state.
   sdt_state_t s;   // Next state.

   // Storage; kept outside the record since it is never reset.
   logic [DQ_W-1:0] mem [0:(1<<MEM_AW)-1];

   sdt_cmd_t cmd;                 // Decoded command.
   logic [BW-1:0] cmd_bank;       // Bank named by the pins.
   logic precharge_sel_bit;       // Auto or all-bank precharge.
   logic en;                      // Internal clock running.
   logic fetch;                   // Read a word at this edge.
   logic wr_beat;                 // Write a word at this edge.
   logic [BW-1:0] acc_bank;       // Bank of this edge's beat.
   logic [COL_W-1:0] acc_col;     // Column of this edge's beat.
   logic [MEM_AW-1:0] mem_addr;   // Storage address of the beat.
   logic [DQ_W-1:0] mem_q;        // Word read at mem_addr.
   logic out_v;                   // Word due on the pins.
   logic [DQ_W-1:0] out_d;

   assign cmd_bank = {bank_sel_hi, bank_sel_lo};
   assign precharge_sel_bit = addr[`SDT_PRE_SEL_BIT];
   // Clock suspend acts one edge after the gate is sampled.
   assign en = r.cke_d;
   // Storage row comes from the row held open in that bank.
   assign mem_addr = {acc_bank,
                      r.row[acc_bank][ROW_STORE_W-1:0],
                      acc_col};
   assign mem_q = mem[mem_addr];

   // Next column inside the burst wraps on the burst boundary.
   function automatic logic [COL_W-1:0] col_step(
      input logic [COL_W-1:0] c);
      logic [BL_W-1:0] lo;
      lo = c[BL_W-1:0] + 1'b1;
      col_step = {c[COL_W-1:BL_W], lo};
   endfunction

   // *************************************************************
   // Command decode
   // *************************************************************

   // Pins are taken as found at the rising edge; a deselected
   // device sees no command.
   always_comb begin
      cmd = SDT_NOP;
      if (!cs_b) begin
         unique case ({ras_b, cas_b, we_b})
            3'b011: cmd = SDT_ACT;
            3'b101: cmd = SDT_RD;
            3'b100: cmd = SDT_WR;
            3'b110: cmd = SDT_BST;
            3'b010: cmd = SDT_PRE;
            3'b001: cmd = SDT_REF;
            3'b000: cmd = SDT_LMR;
            3'b111: cmd = SDT_NOP;
         endcase
      end
   end

   // *************************************************************
   // Next-state logic
   // *************************************************************

   // Burst progress first, then the new command, which may cut
   // the burst short. While the clock is suspended only the gate and mask samples update and the error flag clears.
   always_comb begin
      s = r;
      s.cke_d = cke;
      s.dqm_d = dqm;
      s.err = 1'b0;
      fetch = 1'b0;
      wr_beat = 1'b0;
      acc_bank = r.bank;
      acc_col = r.col;
      out_v = 1'b0;
      out_d = r.dout;
      if (en) begin
         // A burst in progress moves one column per clock.
         if (r.burst != SDT_IDLE) begin
            fetch = (r.burst == SDT_READ);
            wr_beat = (r.burst == SDT_WRITE);
            s.col = col_step(r.col);
            s.left = r.left - 1'b1;
            if (r.left == (BL_W+1)'(1)) begin
               s.burst = SDT_IDLE;
               if (r.ap) begin
                  s.open[r.bank] = 1'b0;
               end
            end
         end
         unique case (cmd)
            SDT_ACT: begin
               // A second activate to an open bank is refused.
               if (r.open[cmd_bank]) begin
                  s.err = 1'b1;
               end else begin
                  s.open[cmd_bank] = 1'b1;
                  s.row[cmd_bank] = addr;
               end
            end
            SDT_RD, SDT_WR: begin
               // Column commands may follow each other on every
               // clock; each one restarts the burst.
               if (!r.open[cmd_bank]) begin
                  s.err = 1'b1;
               end else begin
                  acc_bank = cmd_bank;
                  acc_col = addr[COL_W-1:0];
                  fetch = (cmd == SDT_RD);
                  wr_beat = (cmd == SDT_WR);
                  s.burst = (cmd == SDT_RD) ? SDT_READ : SDT_WRITE;
                  s.bank = cmd_bank;
                  s.col = col_step(addr[COL_W-1:0]);
                  s.left = BEATS_AFTER;
                  s.ap = precharge_sel_bit;
               end
            end
            SDT_BST: begin
               // The beat at the stop edge is not transferred.
               s.burst = SDT_IDLE;
               fetch = 1'b0;
               wr_beat = 1'b0;
            end
            SDT_PRE: begin
               if (precharge_sel_bit) begin
                  s.open = '0;
               end else begin
                  s.open[cmd_bank] = 1'b0;
               end
               // A precharge to the bursting bank stops fetching;
               // words already fetched drain for the read latency.
               if (r.burst != SDT_IDLE &&
                   (precharge_sel_bit || cmd_bank == r.bank)) begin
                  s.burst = SDT_IDLE;
                  fetch = 1'b0;
                  wr_beat = 1'b0;
               end
            end
            SDT_REF: begin
               // Refresh needs every bank idle.
               if (r.open != '0) begin
                  s.err = 1'b1;
               end else if (r.refs != `SDT_INIT_REFRESHES) begin
                  s.refs = r.refs + 1'b1;
                  if (r.refs + 1'b1 == `SDT_INIT_REFRESHES) begin
                     s.ready = 1'b1;
                  end
               end
            end
            SDT_LMR: begin
               // Mode load needs every bank idle; zero is not a
               // legal latency and is taken as the smallest.
               if (r.open != '0) begin
                  s.err = 1'b1;
               end else if (read_latency == 2'd0) begin
                  s.rl = `SDT_RL_MIN;
               end else begin
                  s.rl = read_latency;
               end
            end
            SDT_NOP: begin
               s.err = 1'b0;
            end
         endcase
         // Read pipe: the output flop loads latency-1 edges after
         // the fetch so the word is sampled latency edges after.
         s.p0v = fetch;
         s.p0d = mem_q;
         s.p1v = r.p0v;
         s.p1d = r.p0d;
         unique case (r.rl)
            2'd1: begin
               out_v = fetch;
               out_d = mem_q;
            end
            2'd2: begin
               out_v = r.p0v;
               out_d = r.p0d;
            end
            default: begin
               out_v = r.p1v;
               out_d = r.p1d;
            end
         endcase
         if (out_v) begin
            s.dout = out_d;
         end
         // Mask seen one edge ago floats the lane from this edge,
         // so the controller sees high impedance two edges after.
         s.oe = out_v ? ~r.dqm_d : '0;
      end
   end

   // *************************************************************
   // State register
   // *************************************************************

   // The whole record resets to constants.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.rl <= `SDT_RL_RST;
      end else begin
         r <= s;
      end
   end

   // *************************************************************
   // Storage write port
   // *************************************************************

   // Write data and its mask are taken on the same edge; a masked
   // lane keeps its old contents.
   always_ff @(posedge ref_clk) begin
      if (wr_beat) begin
         for (int l = 0; l < MASK_W; l++) begin
            if (!dqm[l]) begin
               mem[mem_addr][l*LANE_W +: LANE_W] <=
                  dq_in[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // *************************************************************
   // Outputs
   // *************************************************************

   assign dq_out = r.dout;
   assign dq_oe = r.oe;
   assign suspended = ~r.cke_d;
   assign bank_open = r.open;
   assign init_done = r.ready;
   assign cmd_error = r.err;

endmodule

`default_nettype wire

// File: sim/sdt_sdram_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Port checker for the DRAM core
// ********************************
module sdt_sdram_core_assertions #(
   parameter int DQ_W = 16,
   parameter int MASK_W = 2,
   parameter int ROW_W = 12
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cke,
   input wire logic cs_b,
   input wire logic ras_b,
   input wire logic cas_b,
   input wire logic we_b,
   input wire logic bank_sel_lo,
   input wire logic bank_sel_hi,
   input wire logic [ROW_W-1:0] addr,
   input wire logic [MASK_W-1:0] dqm,
   input wire logic [1:0] read_latency,
   input wire logic [DQ_W-1:0] dq_out,
   input wire logic [MASK_W-1:0] dq_oe,
   input wire logic suspended,
   input wire logic [3:0] bank_open,
   input wire logic cmd_error
);
   // Commands count only when the gate was high at the last edge.
   wire go = !suspended && !cs_b;
   wire [1:0] bk = {bank_sel_hi, bank_sel_lo};
   wire act = go && !ras_b && cas_b && we_b;
   wire pre = go && !ras_b && cas_b && !we_b;
   wire lmr = go && !ras_b && !cas_b && !we_b && bank_open == 4'h0;
   logic [1:0] rl_r;
   // Latency copy; zero is kept as one, as the core does.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) rl_r <= 2'h3;
      else if (lmr) rl_r <= (read_latency == 2'h0) ? 2'h1 : read_latency;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Two edges in a row with the internal clock running.
   sequence run2_s;
      !suspended ##1 !suspended;
   endsequence
   sequence rd_s;
      go && ras_b && !cas_b && we_b && bank_open[bk] && rl_r == 2'h2 &&
         dqm == 2'h0;
   endsequence
   sus_enter_a: assert property ($fell(cke) |=> suspended)
      else $error("suspend entry late");
   sus_exit_a: assert property ($rose(cke) |=> !suspended)
      else $error("suspend exit late");
   act_open_a: assert property (act && !bank_open[bk] |=>
      bank_open[$past(bk)]) else $error("activate lost");
   act_err_a: assert property (act && bank_open[bk] |=> cmd_error)
      else $error("double activate unflagged");
   pre_close_a: assert property (pre |=> ($past(addr[10]) ?
      bank_open == 4'h0 : !bank_open[$past(bk)])) else $error("bank open");
   rd_mask_a: assert property (dqm[0] ##1 run2_s |-> !dq_oe[0])
      else $error("masked lane driven");
   rd_lat_a: assert property (rd_s ##1 run2_s |-> dq_oe == 2'h3)
      else $error("read word missing");
   pre_rel_a: assert property (pre && addr[10] && rl_r == 2'h2
      ##1 run2_s |-> dq_oe == 2'h0) else $error("no release");
endmodule
bind sdt_sdram_core sdt_sdram_core_assertions #(.DQ_W(DQ_W),
   .MASK_W(MASK_W), .ROW_W(ROW_W)) chk_i (
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .cke(cke),
   .cs_b(cs_b),
   .ras_b(ras_b),
   .cas_b(cas_b),
   .we_b(we_b),
   .bank_sel_lo(bank_sel_lo),
   .bank_sel_hi(bank_sel_hi),
   .addr(addr),
   .dqm(dqm),
   .read_latency(read_latency),
   .dq_out(dq_out),
   .dq_oe(dq_oe),
   .suspended(suspended),
   .bank_open(bank_open),
   .cmd_error(cmd_error)
);
`default_nettype wire

// File: sim/sdt_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************
// Controller model driving the command pins
// ********************************************
module sdt_ctl_model
   import sdt_pkg::*;
(
   input wire logic ref_clk,
   output logic cke,
   output logic cs_b,
   output logic ras_b,
   output logic cas_b,
   output logic we_b,
   output logic bank_sel_lo,
   output logic bank_sel_hi,
   output logic [11:0] addr,
   output logic [1:0] dqm,
   output logic [15:0] dq_in,
   output logic [1:0] read_latency
);
   // Pin codes in the order of the command type.
   localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h6,
      3'h2, 3'h1, 3'h0};
   initial begin
      {cke, cs_b, ras_b, cas_b, we_b} = 5'h1F;
      {bank_sel_hi, bank_sel_lo, dqm, read_latency} = 6'h03;
      addr = 12'h000;
      dq_in = 16'h0000;
   end
   // One command per call, 1 ns after an edge; a NOP deselects. Data
   // not due on the bus is inverted, so stale data never matches.
   task automatic step(input sdt_cmd_t c, input logic [1:0] b,
         input logic [11:0] a, input logic [1:0] m, input logic w,
         input logic [15:0] d);
      @(posedge ref_clk);
      #1;
      cs_b = (c == SDT_NOP);
      {ras_b, cas_b, we_b} = ENC[c];
      {bank_sel_hi, bank_sel_lo} = b;
      addr = a;
      dqm = m;
      dq_in = w ? d : ~dq_in;
   endtask
   task automatic idle(input int n);
      repeat (n) step(SDT_NOP, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
   endtask
   // Mode load, then the wait before any activate or refresh.
   task automatic mode(input logic [1:0] rl);
      read_latency = rl;
      step(SDT_LMR, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
      idle(2);
   endtask
   // Clock gate change, launched like a command.
   task automatic gate(input logic v);
      @(posedge ref_clk);
      #1;
      cke = v;
   endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import sdt_pkg::*;
;
   typedef struct packed {
      logic [1:0] rl;
      logic [1:0] bank;
      logic [7:0] wc;
      logic [7:0] rc;
      logic ap;
      logic [15:0] base;
   } sdt_row_t;
   // Latency, bank, write and read column, auto precharge, first word.
   localparam sdt_row_t ROWS [4] = '{'{2'h1, 2'h0, 8'h04, 8'h04, 1'b0,
      16'h1000}, '{2'h2, 2'h1, 8'h06, 8'h04, 1'b1, 16'h2200},
      '{2'h3, 2'h2, 8'hFF, 8'hFC, 1'b0, 16'h3300},
      '{2'h0, 2'h3, 8'h09, 8'h0B, 1'b1, 16'h4400}};
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cke, cs_b, ras_b, cas_b, we_b, bank_sel_lo, bank_sel_hi;
   logic suspended, init_done, cmd_error;
   logic [11:0] addr;
   logic [1:0] dqm, read_latency, dq_oe;
   logic [15:0] dq_in, dq_out;
   logic [3:0] bank_open;
   int fails = 0;
   int checked = 0;
   // The clock never stops or changes rate, so every access sees it.
   always #5 ref_clk = ~ref_clk;
   sdt_ctl_model ctl (.ref_clk(ref_clk), .cke(cke), .cs_b(cs_b),
      .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .addr(addr), .dqm(dqm),
      .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi),
      .dq_in(dq_in), .read_latency(read_latency));
   // A small row store keeps memory tiny; rows alias modulo four.
   sdt_sdram_core #(.ROW_STORE_W(2)) uut (.ref_clk(ref_clk),
      .rst_b(rst_b), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
      .cas_b(cas_b), .we_b(we_b), .bank_sel_lo(bank_sel_lo),
      .bank_sel_hi(bank_sel_hi), .addr(addr), .dqm(dqm), .dq_in(dq_in),
      .read_latency(read_latency), .dq_out(dq_out), .dq_oe(dq_oe),
      .suspended(suspended), .bank_open(bank_open),
      .init_done(init_done), .cmd_error(cmd_error));
   task automatic chk(input string n, input logic [15:0] s,
         input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Write four beats, read the block back, then see the bank closed.
   task automatic burst(input sdt_row_t r, input int mw);
      int k;
      int rl;
      int c;
      logic [15:0] e;
      logic [15:0] m;
      rl = (r.rl == 2'h0) ? 1 : int'(r.rl);
      for (k = 0; k < 4; k++) begin
         ctl.step(k == 0 ? SDT_WR : SDT_NOP, r.bank, {4'h0, r.wc},
            k == mw ? 2'h1 : 2'h0, 1'b1, r.base + 16'(k));
      end
      ctl.step(SDT_RD, r.bank, {1'b0, r.ap, 2'h0, r.rc}, 2'h0, 1'b0,
         16'h0000);
      for (k = 1; k <= rl + 3; k++) begin
         ctl.step(SDT_NOP, r.bank, 12'h000, k == mw + rl - 2 ? 2'h2 :
            2'h0, 1'b0, 16'h0000);
         if (k >= rl) begin
            c = (int'(r.rc) - int'(r.wc) + k - rl) & 3;
            e = r.base + 16'(c);
            if (c == mw) e[7:0] = 8'(c);
            m = (k - rl == mw) ? 16'h00FF : 16'hFFFF;
            chk("read data", dq_out & m, e & m);
            chk("read enable", 16'(dq_oe), 16'({m[15], 1'b1}));
         end
      end
      if (!r.ap) ctl.step(SDT_PRE, r.bank, 12'h000, 2'h0, 1'b0, 16'h0000);
      ctl.idle(5);
      chk("bank closed", 16'(bank_open[r.bank]), 16'h0000);
      $display("test burst bank %0d done", r.bank);
   endtask
   initial begin
      #200_000;
      fails++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      chk("reset state", 16'({suspended, init_done, cmd_error, dq_oe,
         bank_open}), 16'h0100);
      $display("test reset done");
      #1;
      rst_b = 1'b1;
      ctl.idle(10000);
      ctl.step(SDT_REF, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
      ctl.step(SDT_REF, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
      chk("one refresh", 16'(init_done), 16'h0000);
      ctl.idle(1);
      chk("two refreshes", 16'(init_done), 16'h0001);
      $display("test wake-up done");
      foreach (ROWS[i]) begin
         ctl.mode(ROWS[i].rl);
         ctl.step(SDT_ACT, ROWS[i].bank, 12'h0A5, 2'h0, 1'b0, 16'h0000);
         ctl.idle(2);
         burst(ROWS[i], 7);
      end
      ctl.mode(2'h2);
      ctl.step(SDT_ACT, 2'h0, 12'h0A5, 2'h0, 1'b0, 16'h0000);
      ctl.idle(2);
      burst('{2'h2, 2'h0, 8'h04, 8'h04, 1'b0, 16'h55A0}, 1);
      ctl.step(SDT_ACT, 2'h1, 12'h0A5, 2'h0, 1'b0, 16'h0000);
      ctl.idle(2);
      ctl.step(SDT_RD, 2'h1, 12'h004, 2'h0, 1'b0, 16'h0000);
      ctl.step(SDT_RD, 2'h1, 12'h005, 2'h0, 1'b0, 16'h0000);
      ctl.step(SDT_PRE, 2'h0, 12'h400, 2'h0, 1'b0, 16'h0000);
      chk("cut word 0", dq_out, 16'h2202);
      ctl.idle(1);
      chk("second read", dq_out, 16'h2203);
      ctl.idle(1);
      chk("cut release", 16'({dq_oe, bank_open}), 16'h0000);
      $display("test precharge cut done");
      ctl.step(SDT_ACT, 2'h2, 12'h0A5, 2'h0, 1'b0, 16'h0000);
      ctl.step(SDT_ACT, 2'h2, 12'h0A5, 2'h0, 1'b0, 16'h0000);
      ctl.idle(1);
      chk("double activate", 16'(cmd_error), 16'h0001);
      ctl.step(SDT_RD, 2'h3, 12'h000, 2'h0, 1'b0, 16'h0000);
      ctl.idle(1);
      chk("idle bank read", 16'(cmd_error), 16'h0001);
      ctl.gate(1'b0);
      ctl.step(SDT_ACT, 2'h3, 12'h0A5, 2'h0, 1'b0, 16'h0000);
      chk("suspend entry", 16'(suspended), 16'h0001);
      ctl.gate(1'b1);
      ctl.idle(1);
      chk("suspend exit", 16'(suspended), 16'h0000);
      chk("frozen activate", 16'(bank_open), 16'h0004);
      $display("test errors and gate done");
      // A burst stop one clock after the second beat drops the third,
      // so that column keeps the word written by an earlier burst.
      ctl.step(SDT_WR, 2'h2, 12'h0FC, 2'h0, 1'b1, 16'hA000);
      ctl.step(SDT_NOP, 2'h2, 12'h000, 2'h0, 1'b1, 16'hA001);
      ctl.step(SDT_BST, 2'h2, 12'h000, 2'h0, 1'b1, 16'hA002);
      ctl.step(SDT_RD, 2'h2, 12'h0FC, 2'h0, 1'b0, 16'h0000);
      ctl.idle(2);
      chk("stop word 0", dq_out, 16'hA000);
      ctl.idle(1);
      chk("stop word 1", dq_out, 16'hA001);
      ctl.idle(1);
      chk("stop kept", dq_out, 16'h3303);
      ctl.idle(1);
      chk("stop word 3", dq_out, 16'h3300);
      $display("test burst stop done");
      conclude();
   end
endmodule
`default_nettype wire
